// ### src/vec_int_pkg.sv
package vec_int_pkg;

    // Wishbone byte addresses
    localparam logic [7:0] ADDR_FLAG    = 8'h00;
    localparam logic [7:0] ADDR_MASK    = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATE   = 8'h0c;
    localparam logic [7:0] ADDR_SH_ACC  = 8'h10;
    localparam logic [7:0] ADDR_SH_STAT = 8'h14;
    localparam logic [7:0] ADDR_SH_PTR  = 8'h18;

    // Source bit positions in flag and mask registers
    localparam int SRC_TICK = 0;
    localparam int SRC_PIN  = 1;
    localparam int SRC_EXT  = 2;
    localparam int SRC_CONV = 3;
    localparam int SRC_TM1  = 4;
    localparam int SRC_TM2  = 5;
    localparam int SRC_CMP  = 6;
    localparam int SRC_LVD  = 7;

    // Option control register fields
    localparam int CTL_EDGE   = 0;
    localparam int CTL_FILTER = 1;
    localparam int CTL_LXT    = 2;
    localparam int CTL_RUN    = 3;

    // State register fields
    localparam int ST_GE      = 0;
    localparam int ST_SERVICE = 1;
    localparam int ST_ASLEEP  = 2;

    // Reset values
    localparam logic [7:0] FLAG_RESET    = 8'h00;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h02;

    // Vector addresses
    localparam logic [9:0] VEC_EXT  = 10'h003;
    localparam logic [9:0] VEC_PIN  = 10'h006;
    localparam logic [9:0] VEC_TICK = 10'h009;
    localparam logic [9:0] VEC_CONV = 10'h00c;
    localparam logic [9:0] VEC_CMP  = 10'h00f;
    localparam logic [9:0] VEC_TM1  = 10'h012;
    localparam logic [9:0] VEC_TM2  = 10'h015;
    localparam logic [9:0] VEC_LVD  = 10'h018;

    typedef struct packed {
        logic       boundary;
        logic       enable_interrupts_instruction;
        logic       disable_interrupts_instruction;
        logic       return_from_interrupt_instruction;
        logic       sleep;
        logic [7:0] acc;
        logic [7:0] status;
        logic [7:0] pointer;
    } core_cmd_type;

    typedef struct packed {
        logic       take;
        logic       wake;
        logic       restore;
        logic [9:0] vector;
        logic [7:0] acc;
        logic [7:0] status;
        logic [7:0] pointer;
    } core_rsp_type;

    typedef enum logic [2:0] {
        SEQ_RUN     = 3'b001,
        SEQ_SERVICE = 3'b010,
        SEQ_ASLEEP  = 3'b100
    } seq_state_type;

endpackage

// ### src/vectored_interrupt_unit.sv
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Operation
// - Seven source kinds: tick, pin change, external, conversion, timers, comparator, low voltage.
// - Enabled external interrupt vectors next fetch to 003H.
// - Pin change vectors to 006H with global enable, else only wakes.
// - Wake with global enable clear resumes at the next instruction.
// - Tick counter, timer one, timer two vector to 009, 012, 015.
// - Conversion complete vectors to 00CH.
// - Comparator change vectors to 00FH.
// - Low-voltage detect vectors to 018H.
// - Fixed priority: low voltage, external, pin change, tick, conversion, comparator, timers.
// - Any port pin changing state raises the pin change event.
// - Pin change enabled before sleep wakes the core.
// - Optional noise filter on external pin, bypassed in low crystal mode.
// - Edge-select bit picks the external pin's active edge.
// - Each source has a mask bit; masked-in flags set regardless of global enable.
// - Flag register reads as flags AND mask.
// - Enable instruction sets global enable, disable instruction clears it.
// - Return instruction ends service and sets global enable.
// - Entry saves accumulator, status word and pointer into shadows.
// - A later entry overwrites the single shadow level.
// - Return restores accumulator, status word and pointer from shadows.
// - Conversion done clears the run bit and sets the conversion flag.
module vectored_interrupt_unit (
    // Clock, reset, enable
    input  wire logic                     REF_CLK_I,
    input  wire logic                     RST_N_I,
    input  wire logic                     CE_I,
    // Wishbone slave
    input  wire logic                     WB_CYC_I,
    input  wire logic                     WB_STB_I,
    input  wire logic                     WB_WE_I,
    input  wire logic [7:0]               WB_ADR_I,
    input  wire logic [3:0]               WB_SEL_I,
    input  wire logic [31:0]              WB_DAT_I,
    output logic      [31:0]              WB_DAT_O,
    output logic                          WB_ACK_O,
    // Interrupt sources
    input  wire logic                     TICK_OVF_I,
    input  wire logic [7:0]               PORT_PIN_I,
    input  wire logic                     EXT_PIN_I,
    input  wire logic                     CONV_DONE_I,
    input  wire logic                     TM1_MATCH_I,
    input  wire logic                     TM2_MATCH_I,
    input  wire logic                     CMP_OUT_I,
    input  wire logic                     LVD_I,
    // Converter control
    output logic                          CONV_RUN_O,
    // Core sequencing
    input  wire vec_int_pkg::core_cmd_type CORE_CMD_I,
    output vec_int_pkg::core_rsp_type      CORE_RSP_O,
    output logic                          SLEEPING_O
);

    // Synchronisers
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] pin_ref;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_hold;
    logic       ext_clean;
    logic       ext_prev;
    logic       cmp_prev;

    // Registers
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] control;
    logic       global_en;
    logic [7:0] shadow_acc;
    logic [7:0] shadow_stat;
    logic [7:0] shadow_ptr;
    logic       ack;
    logic [31:0] rd_data;

    vec_int_pkg::seq_state_type state;
    vec_int_pkg::seq_state_type next_state;
    vec_int_pkg::core_rsp_type  rsp;

    // Decode and event nets
    logic       bus_req;
    logic       wr_now;
    logic       wr_flag;
    logic       wr_mask;
    logic       wr_ctl;
    logic [7:0] flag_view;
    logic [7:0] state_view;
    logic       filter_on;
    logic       ext_level;
    logic       ext_rise;
    logic       ext_fall;
    logic       ext_edge;
    logic       pin_change;
    logic       cmp_change;
    logic [7:0] events;
    logic [7:0] set_bits;
    logic [7:0] keep_bits;
    logic [7:0] next_flags;
    logic [7:0] pending;
    logic       irq;
    logic       asleep;
    logic       ge_open;
    logic       wake_now;
    logic       take_now;
    logic       restore_now;

    // Priority encoder to vector address
    function automatic logic [9:0] pick_vector(input logic [7:0] pend);
        logic [9:0] v;
        v = vec_int_pkg::VEC_TM2;
        if (pend[vec_int_pkg::SRC_LVD]) begin
            v = vec_int_pkg::VEC_LVD;
        end else if (pend[vec_int_pkg::SRC_EXT]) begin
            v = vec_int_pkg::VEC_EXT;
        end else if (pend[vec_int_pkg::SRC_PIN]) begin
            v = vec_int_pkg::VEC_PIN;
        end else if (pend[vec_int_pkg::SRC_TICK]) begin
            v = vec_int_pkg::VEC_TICK;
        end else if (pend[vec_int_pkg::SRC_CONV]) begin
            v = vec_int_pkg::VEC_CONV;
        end else if (pend[vec_int_pkg::SRC_CMP]) begin
            v = vec_int_pkg::VEC_CMP;
        end else if (pend[vec_int_pkg::SRC_TM1]) begin
            v = vec_int_pkg::VEC_TM1;
        end
        return v;
    endfunction

    // Zero-extend a register byte onto the bus
    function automatic logic [31:0] widen(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    // Bus decode
    assign bus_req    = WB_CYC_I & WB_STB_I;
    assign wr_now     = bus_req & WB_WE_I & ack & WB_SEL_I[0];
    assign wr_flag    = wr_now & (WB_ADR_I == vec_int_pkg::ADDR_FLAG);
    assign wr_mask    = wr_now & (WB_ADR_I == vec_int_pkg::ADDR_MASK);
    assign wr_ctl     = wr_now & (WB_ADR_I == vec_int_pkg::ADDR_CONTROL);
    assign flag_view  = flags & mask;
    assign state_view = {5'h00,
                         state == vec_int_pkg::SEQ_ASLEEP,
                         state == vec_int_pkg::SEQ_SERVICE,
                         global_en};

    always_comb begin
        case (WB_ADR_I)
            vec_int_pkg::ADDR_FLAG:    rd_data = widen(flag_view);
            vec_int_pkg::ADDR_MASK:    rd_data = widen(mask);
            vec_int_pkg::ADDR_CONTROL: rd_data = widen(control);
            vec_int_pkg::ADDR_STATE:   rd_data = widen(state_view);
            vec_int_pkg::ADDR_SH_ACC:  rd_data = widen(shadow_acc);
            vec_int_pkg::ADDR_SH_STAT: rd_data = widen(shadow_stat);
            vec_int_pkg::ADDR_SH_PTR:  rd_data = widen(shadow_ptr);
            default:                   rd_data = 32'h00000000;
        endcase
    end

    // Event detection
    assign filter_on  = control[vec_int_pkg::CTL_FILTER] & ~control[vec_int_pkg::CTL_LXT];
    assign ext_level  = filter_on ? ext_clean : ext_sync;
    assign ext_rise   = ext_level & ~ext_prev;
    assign ext_fall   = ~ext_level & ext_prev;
    assign ext_edge   = control[vec_int_pkg::CTL_EDGE] ? ext_rise : ext_fall;
    assign pin_change = |(pin_sync ^ pin_ref);
    assign cmp_change = CMP_OUT_I ^ cmp_prev;

    assign events     = {LVD_I, cmp_change, TM2_MATCH_I, TM1_MATCH_I,
                         CONV_DONE_I, ext_edge, pin_change, TICK_OVF_I};
    assign set_bits   = events & mask;
    assign keep_bits  = wr_flag ? WB_DAT_I[7:0] : 8'hff;
    assign next_flags = (flags & keep_bits) | set_bits;
    assign pending    = flags & mask;
    assign irq        = |pending;

    // Sequencer
    assign asleep      = state == vec_int_pkg::SEQ_ASLEEP;
    assign ge_open     = global_en & ~CORE_CMD_I.disable_interrupts_instruction & ~CORE_CMD_I.return_from_interrupt_instruction;
    assign wake_now    = asleep & irq;
    assign take_now    = irq & ge_open & (asleep | CORE_CMD_I.boundary);
    assign restore_now = ~asleep & CORE_CMD_I.return_from_interrupt_instruction;

    always_comb begin
        case (state)
            vec_int_pkg::SEQ_RUN: begin
                if (take_now) begin
                    next_state = vec_int_pkg::SEQ_SERVICE;
                end else if (CORE_CMD_I.sleep) begin
                    next_state = vec_int_pkg::SEQ_ASLEEP;
                end else begin
                    next_state = vec_int_pkg::SEQ_RUN;
                end
            end
            vec_int_pkg::SEQ_SERVICE: begin
                if (take_now) begin
                    next_state = vec_int_pkg::SEQ_SERVICE;
                end else if (CORE_CMD_I.return_from_interrupt_instruction) begin
                    next_state = vec_int_pkg::SEQ_RUN;
                end else if (CORE_CMD_I.sleep) begin
                    next_state = vec_int_pkg::SEQ_ASLEEP;
                end else begin
                    next_state = vec_int_pkg::SEQ_SERVICE;
                end
            end
            vec_int_pkg::SEQ_ASLEEP: begin
                if (take_now) begin
                    next_state = vec_int_pkg::SEQ_SERVICE;
                end else if (wake_now) begin
                    next_state = vec_int_pkg::SEQ_RUN;
                end else begin
                    next_state = vec_int_pkg::SEQ_ASLEEP;
                end
            end
            default: next_state = vec_int_pkg::SEQ_RUN;
        endcase
    end

    // Pin synchronisers and edge history
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            pin_meta  <= 8'h00;
            pin_sync  <= 8'h00;
            pin_ref   <= 8'h00;
            ext_meta  <= 1'b0;
            ext_sync  <= 1'b0;
            ext_hold  <= 1'b0;
            ext_clean <= 1'b0;
            ext_prev  <= 1'b0;
            cmp_prev  <= 1'b0;
        end else if (CE_I) begin
            pin_meta  <= PORT_PIN_I;
            pin_sync  <= pin_meta;
            pin_ref   <= pin_sync;
            ext_meta  <= EXT_PIN_I;
            ext_sync  <= ext_meta;
            ext_hold  <= ext_sync;
            if (ext_sync == ext_hold) begin
                ext_clean <= ext_hold;
            end
            ext_prev  <= ext_level;
            cmp_prev  <= CMP_OUT_I;
        end
    end

    // Wishbone handshake and read data
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            ack      <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else if (CE_I) begin
            ack      <= bus_req & ~ack;
            WB_DAT_O <= rd_data;
        end
    end

    assign WB_ACK_O = ack;

    // Flags, mask and control
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            flags   <= vec_int_pkg::FLAG_RESET;
            mask    <= vec_int_pkg::MASK_RESET;
            control <= vec_int_pkg::CONTROL_RESET;
        end else if (CE_I) begin
            flags <= next_flags;
            if (wr_mask) begin
                mask <= WB_DAT_I[7:0];
            end
            if (wr_ctl) begin
                control[2:0] <= WB_DAT_I[2:0];
                control[7:4] <= 4'h0;
            end
            if (CONV_DONE_I) begin
                control[vec_int_pkg::CTL_RUN] <= 1'b0;
            end else if (wr_ctl & WB_DAT_I[vec_int_pkg::CTL_RUN]) begin
                control[vec_int_pkg::CTL_RUN] <= 1'b1;
            end
        end
    end

    assign CONV_RUN_O = control[vec_int_pkg::CTL_RUN];

    // Sequencer state
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state <= vec_int_pkg::SEQ_RUN;
        end else if (CE_I) begin
            state <= next_state;
        end
    end

    // Global enable
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            global_en <= 1'b0;
        end else if (CE_I) begin
            if (take_now) begin
                global_en <= 1'b0;
            end else if (CORE_CMD_I.enable_interrupts_instruction | restore_now) begin
                global_en <= 1'b1;
            end else if (CORE_CMD_I.disable_interrupts_instruction) begin
                global_en <= 1'b0;
            end
        end
    end

    // Single level of shadow copies
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            shadow_acc  <= 8'h00;
            shadow_stat <= 8'h00;
            shadow_ptr  <= 8'h00;
        end else if (CE_I & take_now) begin
            shadow_acc  <= CORE_CMD_I.acc;
            shadow_stat <= CORE_CMD_I.status;
            shadow_ptr  <= CORE_CMD_I.pointer;
        end
    end

    // Core response
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            rsp <= '0;
        end else if (CE_I) begin
            rsp.take    <= take_now;
            rsp.wake    <= wake_now;
            rsp.restore <= restore_now;
            if (take_now) begin
                rsp.vector <= pick_vector(pending);
            end
            if (restore_now) begin
                rsp.acc     <= shadow_acc;
                rsp.status  <= shadow_stat;
                rsp.pointer <= shadow_ptr;
            end
        end
    end

    assign CORE_RSP_O = rsp;
    assign SLEEPING_O = asleep;

endmodule

// ### verification/core_seq_model.sv
`timescale 1ns/100ps
module core_seq_model (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // Executed instructions: enable, disable, return, sleep
    input  wire logic [3:0]                op_i,
    // Controller side
    input  wire vec_int_pkg::core_rsp_type rsp_i,
    input  wire logic                      sleeping_i,
    output vec_int_pkg::core_cmd_type      cmd_o
);
    logic [7:0] accum;
    // Running value so each entry saves something new
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            accum <= 8'h00;
        end else if (rsp_i.restore) begin
            accum <= rsp_i.acc;
        end else begin
            accum <= accum + 8'h01;
        end
    end
    // Fetch halts while asleep
    assign cmd_o = {!sleeping_i, op_i, accum, ~accum, accum ^ 8'h5a};
endmodule

// ### verification/vectored_interrupt_unit_assertions.sv
`timescale 1ns/100ps
module vectored_interrupt_unit_checker (
    // Clock and reset
    input wire logic                      REF_CLK_I,
    input wire logic                      RST_N_I,
    input wire logic                      CE_I,
    // Bus
    input wire logic                      WB_CYC_I,
    input wire logic                      WB_STB_I,
    input wire logic [31:0]               WB_DAT_O,
    input wire logic                      WB_ACK_O,
    // Sources and core
    input wire logic                      CONV_DONE_I,
    input wire logic                      CONV_RUN_O,
    input wire vec_int_pkg::core_cmd_type CORE_CMD_I,
    input wire vec_int_pkg::core_rsp_type CORE_RSP_O,
    input wire logic                      SLEEPING_O
);
    logic [23:0] live;
    logic [23:0] saved;
    // Core values at the entry edge
    always_ff @(posedge REF_CLK_I) begin
        live <= {CORE_CMD_I.acc, CORE_CMD_I.status, CORE_CMD_I.pointer};
        if (!RST_N_I) begin
            saved <= 24'h0;
        end else if (CORE_RSP_O.take) begin
            saved <= live;
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_ack_follows_req: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O && CE_I) |=> WB_ACK_O)
        else $error("bus request not answered in one cycle");
    a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_read_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_take_single: assert property (CORE_RSP_O.take |=> !CORE_RSP_O.take)
        else $error("entry taken twice in a row");
    a_no_take_refused: assert property ((CORE_CMD_I.disable_interrupts_instruction || CORE_CMD_I.return_from_interrupt_instruction) |=> !CORE_RSP_O.take)
        else $error("entry taken beside disable or return");
    a_return_from_interrupt_instruction_restores: assert property ((CORE_CMD_I.return_from_interrupt_instruction && !SLEEPING_O && CE_I) |=> CORE_RSP_O.restore)
        else $error("return gave no restore");
    a_restore_data: assert property (CORE_RSP_O.restore |->
        {CORE_RSP_O.acc, CORE_RSP_O.status, CORE_RSP_O.pointer} == saved)
        else $error("restored values differ from saved ones");
    a_wake_leaves_sleep: assert property (CORE_RSP_O.wake |-> !SLEEPING_O && $past(SLEEPING_O))
        else $error("wake without leaving sleep");
    a_vector_legal: assert property (CORE_RSP_O.take |-> CORE_RSP_O.vector inside
        {10'h003, 10'h006, 10'h009, 10'h00c, 10'h00f, 10'h012, 10'h015, 10'h018})
        else $error("vector outside the table");
    a_done_clears_run: assert property ((CONV_DONE_I && CE_I) |=> !CONV_RUN_O)
        else $error("run bit stays set after done");
endmodule

bind vectored_interrupt_unit vectored_interrupt_unit_checker u_checker (.REF_CLK_I, .RST_N_I, .CE_I, .WB_CYC_I,
    .WB_STB_I, .WB_DAT_O, .WB_ACK_O, .CONV_DONE_I, .CONV_RUN_O, .CORE_CMD_I, .CORE_RSP_O, .SLEEPING_O);

// ### verification/vectored_interrupt_unit_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module vectored_interrupt_unit_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        tick = 1'b0, conv = 1'b0, tm1 = 1'b0, tm2 = 1'b0, lvd = 1'b0, cmp = 1'b0, ext = 1'b0;
    logic [7:0]  pins = 8'h00;
    logic [3:0]  ops = 4'h0;
    logic        run;
    logic        sleeping;
    vec_int_pkg::core_cmd_type cmd;
    vec_int_pkg::core_rsp_type rsp;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          n_rsp = 0;
    int          n_seen = 0;
    logic [11:0] last_rsp = 12'h000;
    int          ord [8] = '{7, 2, 1, 0, 3, 6, 4, 5};
    logic [9:0]  vec [8] = '{10'h018, 10'h003, 10'h006, 10'h009, 10'h00c, 10'h00f, 10'h012, 10'h015};

    always #2 clk = ~clk;

    vectored_interrupt_unit u_vectored_interrupt_unit (.REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .TICK_OVF_I(tick), .PORT_PIN_I(pins), .EXT_PIN_I(ext),
        .CONV_DONE_I(conv), .TM1_MATCH_I(tm1), .TM2_MATCH_I(tm2), .CMP_OUT_I(cmp), .LVD_I(lvd),
        .CONV_RUN_O(run), .CORE_CMD_I(cmd), .CORE_RSP_O(rsp), .SLEEPING_O(sleeping));
    core_seq_model u_core_seq_model (.clk_i(clk), .rst_n_i(rst_n), .op_i(ops), .rsp_i(rsp),
        .sleeping_i(sleeping), .cmd_o(cmd));

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    // Record every entry or wake pulse so none is missed
    always @(posedge clk) begin
        if (rsp.take | rsp.wake) begin
            last_rsp <= {rsp.take, rsp.wake, rsp.vector};
            n_rsp <= n_rsp + 1;
        end
    end

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        `CHK($sformatf("register %h", a), e, q)
    endtask

    task automatic op(input logic [3:0] v);
        @(posedge clk);
        ops <= v;
        @(posedge clk);
        ops <= 4'h0;
    endtask

    // One event of source s in flag bit order
    task automatic fire(input int s);
        @(posedge clk);
        case (s)
            0: tick <= 1'b1;
            1: pins <= ~pins;
            2: ext <= 1'b1;
            3: conv <= 1'b1;
            4: tm1 <= 1'b1;
            5: tm2 <= 1'b1;
            6: cmp <= ~cmp;
            default: lvd <= 1'b1;
        endcase
        @(posedge clk);
        {tick, conv, tm1, tm2, lvd} <= 5'h00;
        repeat (3) @(posedge clk);
        ext <= 1'b0;
    endtask

    task automatic wait_rsp(output logic [11:0] r);
        while (n_rsp == n_seen) begin
            @(posedge clk);
        end
        n_seen++;
        r = last_rsp;
    endtask

    initial begin
        logic [11:0] r;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'h02);
        rd(8'h0c, 8'h00);
        rd(8'h1c, 8'h00);
        fire(0);
        wr(8'h04, 8'hff);
        rd(8'h00, 8'h00);
        $display("test reset and mask done");
        for (int s = 0; s < 8; s++) fire(s);
        repeat (8) @(posedge clk);
        rd(8'h00, 8'hff);
        wr(8'h04, 8'h0f);
        rd(8'h00, 8'h0f);
        wr(8'h04, 8'hff);
        op(4'h8);
        for (int k = 0; k < 8; k++) begin
            wait_rsp(r);
            `CHK("entry vector", {2'b10, vec[k]}, r)
            rd(8'h0c, 8'h02);
            wr(8'h00, ~(8'h01 << ord[k]));
            op(4'h2);
        end
        repeat (4) @(posedge clk);
        rd(8'h0c, 8'h01);
        $display("test vectors and priority done");
        op(4'h4);
        op(4'h1);
        @(posedge clk);
        `CHK("asleep", 1'b1, sleeping)
        fire(1);
        wait_rsp(r);
        `CHK("wake only", 2'b01, r[11:10])
        `CHK("awake", 1'b0, sleeping)
        wr(8'h00, 8'hfd);
        op(4'h8);
        op(4'h1);
        fire(7);
        wait_rsp(r);
        `CHK("wake and entry", {2'b11, 10'h018}, r)
        op(4'h2);
        wait_rsp(r);
        `CHK("recurring entry", {2'b10, 10'h018}, r)
        wr(8'h00, 8'h7f);
        op(4'h2);
        $display("test sleep done");
        op(4'h4);
        wr(8'h08, 8'h03);
        fire(2);
        repeat (8) @(posedge clk);
        rd(8'h00, 8'h04);
        wr(8'h00, 8'hfb);
        for (int g = 0; g < 2; g++) begin
            wr(8'h08, g ? 8'h07 : 8'h03);
            ext <= 1'b1;
            @(posedge clk);
            ext <= 1'b0;
            repeat (8) @(posedge clk);
            rd(8'h00, g ? 8'h04 : 8'h00);
            wr(8'h00, 8'hfb);
        end
        $display("test external pin done");
        wr(8'h08, 8'h0a);
        rd(8'h08, 8'h0a);
        `CHK("run set", 1'b1, run)
        fire(3);
        `CHK("run cleared", 1'b0, run)
        rd(8'h00, 8'h08);
        rd(8'h08, 8'h02);
        $display("test conversion done");
        results();
    end
endmodule
